// >>> hdl/acc_defs.vh
/*
 * Constants of the ADC conversion configuration block: register indices,
 * field positions, reset values, write masks and timing counts.
 * Assumes it is included by bare name from the block's design files.
 */
// Functional notes
// - Reference control bit 7 switches the reference buffer offset compensation on or off.
// - The 4-bit reference select picks internal 1.0 V, supply/1.48, half supply, ref A or ref B.
// - The result adjust field in averaging control bits 6:4 divides the sum by a power of two.
// - The sample count field adds 2^code samples, 1 to 1024, codes above 0xA being reserved.
// - Sampling lasts (sampling length + 1) half periods of the ADC clock, length in bits 5:0.
// - The prescaler divides the peripheral clock by 4 at code 0 doubling up to 512 at code 7.
// - Resolution select gives 12 bits, the 16-bit averaging output, 10 bits or 8 bits.
// - With correction enabled each result is corrected for gain and offset before use.
// - With correction enabled each conversion is lengthened by the ADC half periods set by offset bits 3:0.
// - Free-running clear means single conversions, set means restart on each completion.
// - Left adjust puts the result at the top of the result register, otherwise right aligned.
// - The differential bit selects conversion of the positive minus negative input.
// - The window mode selects disabled, above lower, below upper, between or outside.
// - Writes to synchronized registers take effect after a delay shown by a busy flag.
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

// Register indices; the byte address is four times the index.
`define ACC_IDX_CONTROL      6'h00
`define ACC_IDX_REFERENCE    6'h01
`define ACC_IDX_AVERAGING    6'h02
`define ACC_IDX_SAMPLING     6'h03
`define ACC_IDX_CONVERSION   6'h04
`define ACC_IDX_WINDOW       6'h08
`define ACC_IDX_STATUS       6'h19
`define ACC_IDX_RESULT       6'h1A
`define ACC_IDX_WIN_LOWER    6'h1C
`define ACC_IDX_WIN_UPPER    6'h20
`define ACC_IDX_GAIN         6'h24
`define ACC_IDX_OFFSET       6'h26

// Writable bits of each register.
`define ACC_MASK_CONTROL     16'h0003
`define ACC_MASK_REFERENCE   16'h008F
`define ACC_MASK_AVERAGING   16'h007F
`define ACC_MASK_SAMPLING    16'h003F
`define ACC_MASK_CONVERSION  16'h073F
`define ACC_MASK_WINDOW      16'h0007
`define ACC_MASK_CORR        16'h0FFF

// Reset values.
`define ACC_RST_ZERO         16'h0000
`define ACC_RST_GAIN         12'h800

// Field positions.
`define ACC_REF_COMP_BIT     7
`define ACC_CTL_ENABLE_BIT   1
`define ACC_CTL_START_BIT    0
`define ACC_CB_CORR_BIT      3
`define ACC_CB_FREE_BIT      2
`define ACC_CB_LEFT_BIT      1
`define ACC_CB_DIFF_BIT      0
`define ACC_ST_SYNC_BIT      7

// Codes.
`define ACC_ACC_MAX_CODE     4'hA
`define ACC_RES_12           2'h0
`define ACC_RES_16           2'h1
`define ACC_RES_10           2'h2
`define ACC_RES_8            2'h3
`define ACC_WIN_OFF          3'h0
`define ACC_WIN_ABOVE        3'h1
`define ACC_WIN_BELOW        3'h2
`define ACC_WIN_INSIDE       3'h3
`define ACC_WIN_OUTSIDE      3'h4

// Timing counts in peripheral clock cycles or ADC half periods.
`define ACC_SYNC_CYCLES      4'h4
`define ACC_CONV_HALVES      7'h17

`endif

// >>> hdl/acc_result_path.v
/*
 * Result path: divides the accumulated sum, applies gain and offset
 * correction, cuts to the selected resolution and aligns the value.
 * Assumes a combinational use; the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"

module acc_result_path (
   input  wire [21:0] sum,
   input  wire [2:0]  divide_shift,
   input  wire        corr_en,
   input  wire [11:0] gain,
   input  wire [11:0] offset,
   input  wire [1:0]  res_sel,
   input  wire        left_align,
   output reg  [15:0] result
);

   reg [21:0] divided;
   reg [15:0] base;
   reg [16:0] diff;
   reg [27:0] prod;
   reg [15:0] corr;

   always @* begin
      divided = sum >> divide_shift;
      base = (divided[21:16] != 6'h00) ? 16'hFFFF : divided[15:0];
      diff = {1'b0, base} - {5'h00, offset};
      prod = diff[15:0] * gain;
      if (!corr_en) begin
         corr = base;
      end else if (diff[16]) begin
         corr = 16'h0000;
      end else if (prod[27:27] != 1'b0) begin
         corr = 16'hFFFF;
      end else begin
         corr = prod[26:11];
      end
      if (res_sel != `ACC_RES_16 && corr[15:12] != 4'h0) begin
         corr = 16'h0FFF;
      end
      case (res_sel)
         `ACC_RES_12: result = left_align ? {corr[11:0], 4'h0} : {4'h0, corr[11:0]};
         `ACC_RES_10: result = left_align ? {corr[11:2], 6'h00} : {6'h00, corr[11:2]};
         `ACC_RES_8:  result = left_align ? {corr[11:4], 8'h00} : {8'h00, corr[11:4]};
         default:     result = corr;
      endcase
   end

endmodule
`default_nettype wire

// >>> hdl/acc_top.v
/*
 * ADC conversion configuration: Avalon-MM register slave, prescaler,
 * sampling and conversion sequencer, accumulation, result formatting
 * and window monitor.
 * Assumes RAW_DATA comes from the analog core on an unrelated timing and
 * is stable at the end of each conversion phase.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"

module acc_top (
   input  wire        CLK,
   input  wire        RST_N,
   input  wire [5:0]  AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [3:0]  AVS_BYTEENABLE,
   input  wire [31:0] AVS_WRITEDATA,
   output reg  [31:0] AVS_READDATA,
   output reg         AVS_WAITREQUEST,
   input  wire [11:0] RAW_DATA,
   output reg         ADC_CLK,
   output reg         SAMPLE_EN,
   output reg  [3:0]  REF_SEL,
   output reg         REF_COMP_EN,
   output reg         DIFF_EN,
   output reg         RESULT_VALID,
   output reg         WINDOW_HIT
);

   localparam [1:0] ST_IDLE    = 2'h0;
   localparam [1:0] ST_SAMPLE  = 2'h1;
   localparam [1:0] ST_CONVERT = 2'h2;
   localparam [1:0] ST_DONE    = 2'h3;

   // *************************************************************
   // Functions
   // *************************************************************
   function [15:0] merge;
      input [15:0] old;
      input [31:0] wdata;
      input [3:0]  be;
      input [15:0] mask;
      reg   [15:0] m;
      begin
         m = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
         merge = (m & mask) | (old & ~mask);
      end
   endfunction

   // half period of the ADC clock minus one
   function [7:0] half_len;
      input [2:0] code;
      begin
         half_len = (8'h02 << code) - 8'h01;
      end
   endfunction

   // samples minus one, reserved codes clamp to the largest
   function [10:0] last_sample;
      input [3:0] code;
      reg   [3:0] c;
      begin
         c = (code > `ACC_ACC_MAX_CODE) ? `ACC_ACC_MAX_CODE : code;
         last_sample = (11'h001 << c) - 11'h001;
      end
   endfunction

   function win_match;
      input [2:0]  mode;
      input [15:0] res;
      input [15:0] lo;
      input [15:0] hi;
      begin
         case (mode)
            `ACC_WIN_ABOVE:   win_match = res > lo;
            `ACC_WIN_BELOW:   win_match = res < hi;
            `ACC_WIN_INSIDE:  win_match = (res > lo) && (res < hi);
            `ACC_WIN_OUTSIDE: win_match = !((res > lo) && (res < hi));
            default:          win_match = 1'b0;
         endcase
      end
   endfunction

   // *************************************************************
   // Registers
   // *************************************************************
   reg  [15:0] ctl_q;
   reg  [15:0] ref_q;
   reg  [15:0] avg_q;
   reg  [15:0] samp_q;
   reg  [15:0] cb_q;
   reg  [15:0] win_q;
   reg  [15:0] cb_act_q;
   reg  [15:0] win_act_q;
   reg  [15:0] gain_q;
   reg  [15:0] ofs_q;
   reg  [15:0] lo_q;
   reg  [15:0] hi_q;
   reg  [15:0] result_q;
   reg  [3:0]  sync_cnt_q;
   reg         start_q;
   reg  [1:0]  state_q;
   reg  [7:0]  div_cnt_q;
   reg  [6:0]  half_cnt_q;
   reg  [10:0] num_q;
   reg  [21:0] sum_q;
   reg  [11:0] raw_s1_q;
   reg  [11:0] raw_s2_q;
   reg  [15:0] rd_d;
   wire [15:0] formatted;
   wire        enabled;
   wire        tick;
   wire        req;
   wire        do_write;
   wire        conv_begin;
   wire [21:0] sum_next;

   assign enabled    = ctl_q[`ACC_CTL_ENABLE_BIT];
   assign tick       = enabled && (div_cnt_q == half_len(cb_act_q[10:8]));
   assign req        = AVS_READ || AVS_WRITE;
   assign do_write   = AVS_WRITE && !AVS_WAITREQUEST;
   assign conv_begin = (state_q == ST_IDLE) && enabled && start_q && tick;
   assign sum_next   = sum_q + {10'h000, raw_s2_q};

   always @* begin
      case (AVS_ADDRESS)
         `ACC_IDX_CONTROL:    rd_d = ctl_q;
         `ACC_IDX_REFERENCE:  rd_d = ref_q;
         `ACC_IDX_AVERAGING:  rd_d = avg_q;
         `ACC_IDX_SAMPLING:   rd_d = samp_q;
         `ACC_IDX_CONVERSION: rd_d = cb_q;
         `ACC_IDX_WINDOW:     rd_d = win_q;
         `ACC_IDX_STATUS:     rd_d = {8'h00, sync_cnt_q != 4'h0, 5'h00, WINDOW_HIT,
                                      state_q != ST_IDLE};
         `ACC_IDX_RESULT:     rd_d = result_q;
         `ACC_IDX_WIN_LOWER:  rd_d = lo_q;
         `ACC_IDX_WIN_UPPER:  rd_d = hi_q;
         `ACC_IDX_GAIN:       rd_d = gain_q;
         `ACC_IDX_OFFSET:     rd_d = ofs_q;
         default:             rd_d = 16'h0000;
      endcase
   end

   // *************************************************************
   // Avalon-MM slave
   // *************************************************************
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h00000000;
         ctl_q           <= `ACC_RST_ZERO;
         ref_q           <= `ACC_RST_ZERO;
         avg_q           <= `ACC_RST_ZERO;
         samp_q          <= `ACC_RST_ZERO;
         cb_q            <= `ACC_RST_ZERO;
         win_q           <= `ACC_RST_ZERO;
         lo_q            <= `ACC_RST_ZERO;
         hi_q            <= `ACC_RST_ZERO;
         gain_q          <= {4'h0, `ACC_RST_GAIN};
         ofs_q           <= `ACC_RST_ZERO;
         cb_act_q        <= `ACC_RST_ZERO;
         win_act_q       <= `ACC_RST_ZERO;
         sync_cnt_q      <= 4'h0;
         start_q         <= 1'b0;
      end else begin
         if (req && AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= {16'h0000, rd_d};
         end else begin
            AVS_WAITREQUEST <= 1'b1;
         end
         if (do_write) begin
            case (AVS_ADDRESS)
               `ACC_IDX_CONTROL: begin
                  ctl_q <= merge(ctl_q, AVS_WRITEDATA, AVS_BYTEENABLE, `ACC_MASK_CONTROL)
                           & ~16'h0001;
               end
               `ACC_IDX_REFERENCE:
                  ref_q <= merge(ref_q, AVS_WRITEDATA, AVS_BYTEENABLE, `ACC_MASK_REFERENCE);
               `ACC_IDX_AVERAGING:
                  avg_q <= merge(avg_q, AVS_WRITEDATA, AVS_BYTEENABLE, `ACC_MASK_AVERAGING);
               `ACC_IDX_SAMPLING:
                  samp_q <= merge(samp_q, AVS_WRITEDATA, AVS_BYTEENABLE, `ACC_MASK_SAMPLING);
               `ACC_IDX_CONVERSION:
                  cb_q <= merge(cb_q, AVS_WRITEDATA, AVS_BYTEENABLE, `ACC_MASK_CONVERSION);
               `ACC_IDX_WINDOW:
                  win_q <= merge(win_q, AVS_WRITEDATA, AVS_BYTEENABLE, `ACC_MASK_WINDOW);
               `ACC_IDX_WIN_LOWER:
                  lo_q <= merge(lo_q, AVS_WRITEDATA, AVS_BYTEENABLE, 16'hFFFF);
               `ACC_IDX_WIN_UPPER:
                  hi_q <= merge(hi_q, AVS_WRITEDATA, AVS_BYTEENABLE, 16'hFFFF);
               `ACC_IDX_GAIN:
                  gain_q <= merge(gain_q, AVS_WRITEDATA, AVS_BYTEENABLE, `ACC_MASK_CORR);
               `ACC_IDX_OFFSET:
                  ofs_q <= merge(ofs_q, AVS_WRITEDATA, AVS_BYTEENABLE, `ACC_MASK_CORR);
               default: begin
               end
            endcase
         end
         if (do_write && (AVS_ADDRESS == `ACC_IDX_CONVERSION
                          || AVS_ADDRESS == `ACC_IDX_WINDOW)) begin
            sync_cnt_q <= `ACC_SYNC_CYCLES;
         end else if (sync_cnt_q != 4'h0) begin
            sync_cnt_q <= sync_cnt_q - 4'h1;
         end
         if (sync_cnt_q == 4'h1) begin
            cb_act_q  <= cb_q;
            win_act_q <= win_q;
         end
         // Start request: a new request wins over the clear at conversion start.
         if (do_write && AVS_ADDRESS == `ACC_IDX_CONTROL && AVS_BYTEENABLE[0]
             && AVS_WRITEDATA[`ACC_CTL_START_BIT]) begin
            start_q <= 1'b1;
         end else if (state_q == ST_DONE && enabled && cb_act_q[`ACC_CB_FREE_BIT]) begin
            start_q <= 1'b1;
         end else if (conv_begin || !enabled) begin
            start_q <= 1'b0;
         end
      end
   end

   // *************************************************************
   // Prescaler and analog controls
   // *************************************************************
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_cnt_q   <= 8'h00;
         ADC_CLK     <= 1'b0;
         REF_SEL     <= 4'h0;
         REF_COMP_EN <= 1'b0;
         DIFF_EN     <= 1'b0;
         raw_s1_q    <= 12'h000;
         raw_s2_q    <= 12'h000;
      end else begin
         if (!enabled || tick) begin
            div_cnt_q <= 8'h00;
         end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
         end
         if (!enabled) begin
            ADC_CLK <= 1'b0;
         end else if (tick) begin
            ADC_CLK <= !ADC_CLK;
         end
         REF_SEL     <= ref_q[3:0];
         REF_COMP_EN <= ref_q[`ACC_REF_COMP_BIT];
         DIFF_EN     <= cb_act_q[`ACC_CB_DIFF_BIT];
         raw_s1_q    <= RAW_DATA;
         raw_s2_q    <= raw_s1_q;
      end
   end

   // *************************************************************
   // Sequencer
   // *************************************************************
   acc_result_path u_result_path (
      .sum          (sum_next),
      .divide_shift (avg_q[6:4]),
      .corr_en      (cb_act_q[`ACC_CB_CORR_BIT]),
      .gain         (gain_q[11:0]),
      .offset       (ofs_q[11:0]),
      .res_sel      (cb_act_q[5:4]),
      .left_align   (cb_act_q[`ACC_CB_LEFT_BIT]),
      .result       (formatted)
   );

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q      <= ST_IDLE;
         half_cnt_q   <= 7'h00;
         num_q        <= 11'h000;
         sum_q        <= 22'h000000;
         result_q     <= 16'h0000;
         SAMPLE_EN    <= 1'b0;
         RESULT_VALID <= 1'b0;
         WINDOW_HIT   <= 1'b0;
      end else begin
         RESULT_VALID <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (conv_begin) begin
                  state_q    <= ST_SAMPLE;
                  half_cnt_q <= {1'b0, samp_q[5:0]};
                  num_q      <= 11'h000;
                  sum_q      <= 22'h000000;
                  SAMPLE_EN  <= 1'b1;
               end
            end
            ST_SAMPLE: begin
               if (!enabled) begin
                  state_q   <= ST_IDLE;
                  SAMPLE_EN <= 1'b0;
               end else if (tick && half_cnt_q == 7'h00) begin
                  state_q   <= ST_CONVERT;
                  SAMPLE_EN <= 1'b0;
                  half_cnt_q <= `ACC_CONV_HALVES
                                + (cb_act_q[`ACC_CB_CORR_BIT] ? {3'h0, ofs_q[3:0]} : 7'h00);
               end else if (tick) begin
                  half_cnt_q <= half_cnt_q - 7'h01;
               end
            end
            ST_CONVERT: begin
               if (!enabled) begin
                  state_q <= ST_IDLE;
               end else if (tick && half_cnt_q == 7'h00) begin
                  sum_q <= sum_next;
                  if (num_q == last_sample(avg_q[3:0])) begin
                     state_q  <= ST_DONE;
                     result_q <= formatted;
                  end else begin
                     num_q      <= num_q + 11'h001;
                     state_q    <= ST_SAMPLE;
                     half_cnt_q <= {1'b0, samp_q[5:0]};
                     SAMPLE_EN  <= 1'b1;
                  end
               end else if (tick) begin
                  half_cnt_q <= half_cnt_q - 7'h01;
               end
            end
            ST_DONE: begin
               RESULT_VALID <= 1'b1;
               WINDOW_HIT   <= win_match(win_act_q[2:0], result_q, lo_q, hi_q);
               // Restarts pass through idle so sampling starts on an ADC clock tick.
               state_q      <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> dv/acc_top_assertions.sv
/*
 * Port checks on acc_top.
 * Assumes settings stay put during a conversion.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"

module acc_chk (
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic [5:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic [11:0] RAW_DATA,
   input wire logic        ADC_CLK,
   input wire logic        SAMPLE_EN,
   input wire logic [3:0]  REF_SEL,
   input wire logic        REF_COMP_EN,
   input wire logic        DIFF_EN,
   input wire logic        RESULT_VALID,
   input wire logic        WINDOW_HIT
);
   // ********
   // Mirrors.
   // ********
   wire         wr_done = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
   logic [7:0]  ref_q;
   logic [5:0]  len_q;
   logic [2:0]  psc_q;
   logic [2:0]  tog_q;
   logic        diff_q, free_q, en_q, adc_prev_q;
   logic [9:0]  half_q;
   logic [15:0] samp_q;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         {ref_q, len_q, psc_q, tog_q, diff_q, free_q, en_q, adc_prev_q} <= '0;
         half_q <= 10'h000;
         samp_q <= 16'h0000;
      end else begin
         if (wr_done && AVS_ADDRESS == `ACC_IDX_REFERENCE)
            ref_q <= AVS_WRITEDATA[7:0];
         if (wr_done && AVS_ADDRESS == `ACC_IDX_SAMPLING)
            len_q <= AVS_WRITEDATA[5:0];
         if (wr_done && AVS_ADDRESS == `ACC_IDX_CONTROL)
            en_q <= AVS_WRITEDATA[1];
         if (wr_done && AVS_ADDRESS == `ACC_IDX_CONVERSION)
            {psc_q, free_q, diff_q} <= {AVS_WRITEDATA[10:8], AVS_WRITEDATA[2], AVS_WRITEDATA[0]};
         if ((wr_done && AVS_ADDRESS == `ACC_IDX_CONVERSION) || !en_q)
            tog_q <= 3'h0;
         else if (ADC_CLK != adc_prev_q && tog_q != 3'h7)
            tog_q <= tog_q + 3'h1;
         adc_prev_q <= ADC_CLK;
         half_q <= (ADC_CLK != adc_prev_q) ? 10'h001 : half_q + 10'h001;
         samp_q <= SAMPLE_EN ? samp_q + 16'h0001 : 16'h0000;
      end
   end

   // ********
   // Properties.
   // ********
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_bus_wait;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence s_conv_wr;
      wr_done && AVS_ADDRESS == `ACC_IDX_CONVERSION;
   endsequence

   a_wait_one: assert property (s_bus_wait |=> !AVS_WAITREQUEST)
      else $error("no answer");
   a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("long answer");
   a_unmapped_zero: assert property (s_bus_wait ##0 AVS_READ && AVS_ADDRESS == 6'h3F
      |=> AVS_READDATA == 32'h0) else $error("unmapped read");
   a_ref_select: assert property ($stable(ref_q) [*3] |-> REF_SEL == ref_q[3:0])
      else $error("reference select");
   a_ref_comp: assert property ($stable(ref_q) [*3] |-> REF_COMP_EN == ref_q[7])
      else $error("compensation");
   a_diff_follow: assert property ($stable(diff_q) [*8] |-> DIFF_EN == diff_q)
      else $error("differential");
   a_sync_hold: assert property (s_conv_wr ##0 AVS_WRITEDATA[0] != DIFF_EN
      |=> $stable(DIFF_EN) [*3]) else $error("early setting");
   a_adc_idle: assert property (!en_q [*3] |-> !ADC_CLK)
      else $error("adc clock idle");
   a_adc_half: assert property (en_q && tog_q == 3'h7 && ADC_CLK != adc_prev_q
      |-> half_q == (10'h002 << psc_q)) else $error("adc half period");
   a_sample_len: assert property ($fell(SAMPLE_EN) && en_q
      |-> samp_q == ({10'h000, len_q} + 16'h0001) * (16'h0002 << psc_q))
      else $error("sampling length");
   a_valid_pulse: assert property (RESULT_VALID |=> !RESULT_VALID)
      else $error("valid pulse");
   a_single_stop: assert property (RESULT_VALID && !free_q |=> !SAMPLE_EN [*8])
      else $error("single restart");
   a_free_restart: assert property (RESULT_VALID && free_q && en_q
      |-> ##[1:40] SAMPLE_EN) else $error("free restart");
endmodule

bind acc_top acc_chk chk_u (.*);
`default_nettype wire

// >>> dv/acc_top_bench.sv
/*
 * Self-checking bench for acc_top.
 * Assumes RAW_DATA steady during each conversion.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acc_defs.vh"

module acc_top_bench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  address = 6'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [11:0] raw = 12'h000;
   wire  [31:0] readdata;
   wire  [3:0]  ref_sel;
   wire         waitrequest, adc_clk, sample_en, ref_comp_en, diff_en, result_valid, window_hit;
   integer      n_mismatch = 0, checked = 0, n_valid = 0, tv = 0, cycles = 0, seed = 81717;
   logic [31:0] exp_q [$];
   logic [5:0]  idx [9] = '{`ACC_IDX_CONTROL, `ACC_IDX_REFERENCE, `ACC_IDX_AVERAGING,
      `ACC_IDX_SAMPLING, `ACC_IDX_CONVERSION, `ACC_IDX_WINDOW, `ACC_IDX_GAIN, `ACC_IDX_OFFSET,
      6'h3F};
   logic [15:0] msk [9] = '{16'h0002, 16'h008F, 16'h007F, 16'h003F, 16'h073F, 16'h0007,
      16'h0FFF, 16'h0FFF, 16'h0000};
   logic [11:0] wraw [3] = '{12'h400, 12'h800, 12'h050};
   logic [5:0]  whit [3] = '{6'h0E, 6'h12, 6'h14};
   logic [31:0] atab [4] = '{32'h22000123, 32'h03010918, 32'h1301048C, 32'h04000FFF};

   always #20 clk = ~clk;

   acc_top dut_u (
      .CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
      .AVS_BYTEENABLE(4'h3), .AVS_WRITEDATA(writedata), .AVS_READDATA(readdata),
      .AVS_WAITREQUEST(waitrequest), .RAW_DATA(raw), .ADC_CLK(adc_clk), .SAMPLE_EN(sample_en),
      .REF_SEL(ref_sel), .REF_COMP_EN(ref_comp_en), .DIFF_EN(diff_en),
      .RESULT_VALID(result_valid), .WINDOW_HIT(window_hit)
   );

   // ********
   // Shared tasks.
   // ********
   task automatic compare(input string what, input logic [31:0] e, input logic [31:0] got);
      checked = checked + 1;
      if (got !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected %s expected %h seen %h", what, e, got);
      end
   endtask

   task automatic results;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic bus(input logic wr_en, input logic [5:0] a, input logic [15:0] d);
      integer n;
      @(posedge clk);
      address <= a;
      writedata <= {16'h0000, d};
      read <= !wr_en;
      write <= wr_en;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50) compare("waitrequest", 32'h0, 32'h1);
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      exp_q.push_back({16'h0000, e});
      bus(1'b0, a, 16'h0000);
   endtask

   task automatic wait_valid(output integer n);
      tv = tv + 1;
      n = 0;
      while (n_valid < tv && n < 25000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 25000) compare("result valid", 32'h1, 32'h0);
   endtask

   task automatic convert(input logic [11:0] r, input logic [15:0] e, output integer n);
      raw <= r;
      repeat (8) @(posedge clk);
      wr(`ACC_IDX_CONTROL, 16'h0003);
      wait_valid(n);
      rd(`ACC_IDX_RESULT, e);
   endtask

   function automatic logic [15:0] cfg(input logic [2:0] psc, input logic [1:0] res,
                                       input logic [3:0] bits);
      return {5'h00, psc, 2'b00, res, bits};
   endfunction

   always @(posedge clk) begin
      if (read && !waitrequest) begin
         if (exp_q.size() == 0)
            compare("read queue", 32'h0, 32'h1);
         else
            compare("read data", exp_q.pop_front(), readdata);
      end
      if (result_valid === 1'b1) n_valid <= n_valid + 1;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_mismatch = n_mismatch + 1;
         results();
      end
   end

   // ********
   // Main sequence.
   // ********
   initial begin
      logic [15:0] v;
      logic [11:0] r;
      logic        left;
      integer      n, n0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      compare("adc clock", 32'h0, adc_clk);
      for (int i = 0; i < 9; i++)
         rd(idx[i], (idx[i] == `ACC_IDX_GAIN) ? {4'h0, `ACC_RST_GAIN} : 16'h0000);
      for (int i = 1; i < 9; i++) begin
         wr(idx[i], 16'hFFFF);
         rd(idx[i], msk[i]);
         wr(idx[i], (idx[i] == `ACC_IDX_GAIN) ? {4'h0, `ACC_RST_GAIN} : 16'h0000);
      end
      $display("test registers done");
      for (int c = 0; c < 6; c++) begin
         wr(`ACC_IDX_REFERENCE, {8'h00, c[0], 3'h0, c[3:0]});
         repeat (3) @(posedge clk);
         compare("ref select", c[3:0], ref_sel);
         compare("ref comp", c[0], ref_comp_en);
      end
      $display("test reference done");
      wr(`ACC_IDX_CONVERSION, cfg(3'h0, 2'h0, 4'h1));
      rd(`ACC_IDX_STATUS, 16'h0080);
      repeat (8) @(posedge clk);
      rd(`ACC_IDX_STATUS, 16'h0000);
      compare("diff", 32'h1, diff_en);
      wr(`ACC_IDX_CONVERSION, 16'h0000);
      $display("test sync done");
      wr(`ACC_IDX_CONTROL, 16'h0002);
      rd(`ACC_IDX_CONTROL, msk[0]);
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         left = i[2] && i[1:0] != 2'h1;
         wr(`ACC_IDX_SAMPLING, {13'h0000, r[2:0]});
         wr(`ACC_IDX_CONVERSION, cfg(~i[2:0], i[1:0], {2'b00, left, 1'b0}));
         v = (i[1:0] == 2'h2) ? r >> 2 : (i[1:0] == 2'h3) ? r >> 4 : r;
         if (left) v = v << ((i[1:0] == 2'h0) ? 4 : (i[1:0] == 2'h2) ? 6 : 8);
         convert(r, v, n);
      end
      n0 = n_valid;
      repeat (300) @(posedge clk);
      compare("single", n0, n_valid);
      $display("test resolution done");
      wr(`ACC_IDX_SAMPLING, 16'h0000);
      wr(`ACC_IDX_CONVERSION, 16'h0000);
      wr(`ACC_IDX_WIN_LOWER, 16'h0100);
      wr(`ACC_IDX_WIN_UPPER, 16'h0700);
      for (int k = 0; k < 3; k++)
         for (int m = 0; m < 6; m++) begin
            wr(`ACC_IDX_WINDOW, m[15:0]);
            convert(wraw[k], {4'h0, wraw[k]}, n);
            compare("window hit", whit[k][m], window_hit);
         end
      $display("test window done");
      for (int k = 0; k < 4; k++) begin
         wr(`ACC_IDX_AVERAGING, {8'h00, atab[k][31:24]});
         wr(`ACC_IDX_CONVERSION, cfg(3'h0, atab[k][17:16], 4'h0));
         convert(12'h123, atab[k][15:0], n);
      end
      $display("test accumulation done");
      wr(`ACC_IDX_AVERAGING, 16'h0000);
      wr(`ACC_IDX_CONVERSION, 16'h0000);
      convert(12'h100, 16'h0100, n0);
      wr(`ACC_IDX_OFFSET, 16'h0014);
      wr(`ACC_IDX_GAIN, 16'h0400);
      wr(`ACC_IDX_CONVERSION, cfg(3'h0, 2'h0, 4'h8));
      convert(12'h100, 16'h0076, n);
      compare("longer", 32'h1, n - n0 >= 4 && n - n0 <= 12);
      $display("test correction done");
      wr(`ACC_IDX_CONVERSION, cfg(3'h0, 2'h0, 4'h4));
      convert(12'h2A5, 16'h02A5, n);
      wait_valid(n);
      wait_valid(n);
      repeat (45) @(posedge clk);
      wr(`ACC_IDX_CONTROL, 16'h0000);
      n0 = n_valid;
      repeat (300) @(posedge clk);
      compare("aborted", n0, n_valid);
      compare("adc clock", 32'h0, adc_clk);
      $display("test free running done");
      results();
   end
endmodule
`default_nettype wire
